// file: inc/gpio_bank_pkg.sv
// constants and carrier types for the pin configuration bank
// assumes one 125 MHz clock and an 8-bit register port
package gpio_bank_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int PIN_COUNT = 10;
    localparam int IRQ_BITS = 2;
    // index order: 1.7 2.0 2.1 2.2 2.4 2.5 2.6 2.7 3.0 3.1
    localparam logic [PIN_COUNT-1:0][7:0] PIN_CTL_OFFSET = {
        8'h34, 8'h33, 8'h32, 8'h31, 8'h30, 8'h2F, 8'h2D, 8'h2C, 8'h2B, 8'h2A};
    localparam logic [7:0] OFF_RESERVED_SLOT = 8'h2E;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h41;

    // writable bits per pin; everything else is reserved
    localparam logic [7:0] WMASK_ONE_FUNC = 8'h87;
    localparam logic [7:0] WMASK_TWO_FUNC = 8'h8F;
    localparam logic [7:0] WMASK_NO_FUNC = 8'h83;
    localparam logic [PIN_COUNT-1:0][7:0] PIN_WMASK = {
        WMASK_ONE_FUNC, WMASK_ONE_FUNC, WMASK_ONE_FUNC, WMASK_ONE_FUNC, WMASK_ONE_FUNC,
        WMASK_NO_FUNC, WMASK_TWO_FUNC, WMASK_TWO_FUNC, WMASK_ONE_FUNC, WMASK_ONE_FUNC};

    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam logic [IRQ_BITS-1:0] IRQ_RESET = 2'h0;

    // ----------------------------------------
    // pin indices and function codes
    // ----------------------------------------
    localparam int PIN_1_7 = 0;
    localparam int PIN_2_0 = 1;
    localparam int PIN_2_1 = 2;
    localparam int PIN_2_2 = 3;
    localparam int PIN_2_4 = 4;
    localparam int PIN_2_5 = 5;
    localparam int PIN_2_6 = 6;
    localparam int PIN_2_7 = 7;
    localparam int PIN_3_0 = 8;
    localparam int PIN_3_1 = 9;

    localparam logic [1:0] FUNC_GPIO = 2'h0;
    localparam logic [1:0] FUNC_ALT = 2'h1;
    localparam logic [1:0] FUNC_EDGE = 2'h2;
    localparam logic [1:0] FUNC_FLOPPY = 2'h3;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef struct packed {
        logic openDrain;
        logic [2:0] rsvd;
        logic [1:0] func;
        logic invert;
        logic dirIn;
    } pin_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // values that on-chip functions send towards the pins
    typedef struct packed {
        logic joyBVerticalTimer;
        logic kbcPort1Bit7;
        logic kbcPort1Bit6;
        logic kbcPort1Bit2;
        logic floppyDriveSelectBN;
        logic floppyMotorSelectBN;
        logic musicSerialTx;
        logic sysMgmtIrqOutN;
    } alt_drive_t;

    // logical pin values handed to on-chip functions, zero when not routed
    typedef struct packed {
        logic joyBVerticalTimer;
        logic kbcPort1Bit7;
        logic kbcPort1Bit6;
        logic kbcPort1Bit2;
        logic musicSerialRx;
        logic fanSpeedSenseB;
        logic fanSpeedSenseA;
    } alt_sense_t;

    typedef struct packed {
        pin_cfg_t [PIN_COUNT-1:0] cfg;
        logic [PIN_COUNT-1:0] sync1;
        logic [PIN_COUNT-1:0] sync2;
        logic [PIN_COUNT-1:0] prev;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] mask;
        logic [7:0] rdata;
        logic [PIN_COUNT-1:0] padOut;
        logic [PIN_COUNT-1:0] padOe;
        logic [PIN_COUNT-1:0] gpioIn;
        alt_sense_t sense;
    } state_t;

endpackage : gpio_bank_pkg

// file: src/gpio_pin_config_bank.sv
// configuration bank for general-purpose pins 1.7 to 3.1
// assumes pads resolve level from padOut/padOe; data registers live outside
module gpio_pin_config_bank (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire gpio_bank_pkg::reg_req_t regReq,
    output logic [7:0] regRdata,
    input wire logic [gpio_bank_pkg::PIN_COUNT-1:0] gpioOutData,
    output logic [gpio_bank_pkg::PIN_COUNT-1:0] gpioInData,
    input wire logic [gpio_bank_pkg::PIN_COUNT-1:0] padIn,
    output logic [gpio_bank_pkg::PIN_COUNT-1:0] padOut,
    output logic [gpio_bank_pkg::PIN_COUNT-1:0] padOe,
    input wire gpio_bank_pkg::alt_drive_t altDrive,
    output gpio_bank_pkg::alt_sense_t altSense,
    output logic irq
);

    gpio_bank_pkg::state_t s;
    gpio_bank_pkg::state_t next_s;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        logic [7:0] rd;
        logic [gpio_bank_pkg::PIN_COUNT-1:0] src;
        logic [gpio_bank_pkg::PIN_COUNT-1:0] forceOut;
        logic [gpio_bank_pkg::PIN_COUNT-1:0] forceIn;
        logic [gpio_bank_pkg::PIN_COUNT-1:0] li;
        logic [gpio_bank_pkg::IRQ_BITS-1:0] ev;
        logic outEn;
        logic val;
        rd = 8'h00;
        src = gpioOutData;
        forceOut = '0;
        forceIn = '0;
        li = '0;
        ev = '0;
        outEn = 1'b0;
        val = 1'b0;
        next_s = s;

        // only sync1 feeds sync2; nothing else looks at the first stage
        next_s.sync1 = padIn;
        next_s.sync2 = s.sync1;
        next_s.prev = s.sync2;

        // register writes, reserved bits masked off
        if (regReq.wr)
        begin
            for (int i = 0; i < gpio_bank_pkg::PIN_COUNT; i++)
            begin
                if (regReq.addr == gpio_bank_pkg::PIN_CTL_OFFSET[i])
                begin
                    next_s.cfg[i] = regReq.wdata & gpio_bank_pkg::PIN_WMASK[i];
                end
            end
            if (regReq.addr == gpio_bank_pkg::OFF_IRQ_MASK)
            begin
                next_s.mask = regReq.wdata[gpio_bank_pkg::IRQ_BITS-1:0];
            end
        end

        // read mux; reserved slot and unmapped addresses fall through to zero
        for (int i = 0; i < gpio_bank_pkg::PIN_COUNT; i++)
        begin
            if (regReq.addr == gpio_bank_pkg::PIN_CTL_OFFSET[i])
            begin
                rd = s.cfg[i];
            end
        end
        if (regReq.addr == gpio_bank_pkg::OFF_IRQ_STATUS)
        begin
            rd = {6'h00, s.status};
        end
        if (regReq.addr == gpio_bank_pkg::OFF_IRQ_MASK)
        begin
            rd = {6'h00, s.mask};
        end
        if (regReq.addr == gpio_bank_pkg::OFF_RESERVED_SLOT)
        begin
            rd = 8'h00;
        end
        next_s.rdata = regReq.rd ? rd : 8'h00;

        // logical input value seen through the polarity bit
        for (int i = 0; i < gpio_bank_pkg::PIN_COUNT; i++)
        begin
            li[i] = s.sync2[i] ^ s.cfg[i].invert;
        end
        next_s.gpioIn = li;

        // ----------------------------------------
        // function routing
        // ----------------------------------------
        next_s.sense = '0;
        if (s.cfg[gpio_bank_pkg::PIN_1_7].func[0])
        begin
            src[gpio_bank_pkg::PIN_1_7] = altDrive.joyBVerticalTimer;
            next_s.sense.joyBVerticalTimer = li[gpio_bank_pkg::PIN_1_7];
        end
        if (s.cfg[gpio_bank_pkg::PIN_2_0].func[0])
        begin
            src[gpio_bank_pkg::PIN_2_0] = altDrive.kbcPort1Bit7;
            next_s.sense.kbcPort1Bit7 = li[gpio_bank_pkg::PIN_2_0];
        end
        case (s.cfg[gpio_bank_pkg::PIN_2_1].func)
            gpio_bank_pkg::FUNC_ALT:
            begin
                src[gpio_bank_pkg::PIN_2_1] = altDrive.kbcPort1Bit6;
                next_s.sense.kbcPort1Bit6 = li[gpio_bank_pkg::PIN_2_1];
            end
            gpio_bank_pkg::FUNC_EDGE:
            begin
                forceIn[gpio_bank_pkg::PIN_2_1] = 1'b1;
                ev[0] = s.sync2[gpio_bank_pkg::PIN_2_1] ^ s.prev[gpio_bank_pkg::PIN_2_1];
            end
            gpio_bank_pkg::FUNC_FLOPPY:
            begin
                src[gpio_bank_pkg::PIN_2_1] = altDrive.floppyDriveSelectBN;
                forceOut[gpio_bank_pkg::PIN_2_1] = 1'b1;
            end
            default:
            begin
                forceIn[gpio_bank_pkg::PIN_2_1] = 1'b0;
            end
        endcase
        case (s.cfg[gpio_bank_pkg::PIN_2_2].func)
            gpio_bank_pkg::FUNC_ALT:
            begin
                src[gpio_bank_pkg::PIN_2_2] = altDrive.kbcPort1Bit2;
                next_s.sense.kbcPort1Bit2 = li[gpio_bank_pkg::PIN_2_2];
            end
            gpio_bank_pkg::FUNC_EDGE:
            begin
                forceIn[gpio_bank_pkg::PIN_2_2] = 1'b1;
                ev[1] = s.sync2[gpio_bank_pkg::PIN_2_2] ^ s.prev[gpio_bank_pkg::PIN_2_2];
            end
            gpio_bank_pkg::FUNC_FLOPPY:
            begin
                src[gpio_bank_pkg::PIN_2_2] = altDrive.floppyMotorSelectBN;
                forceOut[gpio_bank_pkg::PIN_2_2] = 1'b1;
            end
            default:
            begin
                forceIn[gpio_bank_pkg::PIN_2_2] = 1'b0;
            end
        endcase
        if (s.cfg[gpio_bank_pkg::PIN_2_5].func[0])
        begin
            forceIn[gpio_bank_pkg::PIN_2_5] = 1'b1;
            next_s.sense.musicSerialRx = li[gpio_bank_pkg::PIN_2_5];
        end
        if (s.cfg[gpio_bank_pkg::PIN_2_6].func[0])
        begin
            src[gpio_bank_pkg::PIN_2_6] = altDrive.musicSerialTx;
            forceOut[gpio_bank_pkg::PIN_2_6] = 1'b1;
        end
        if (s.cfg[gpio_bank_pkg::PIN_2_7].func[0])
        begin
            src[gpio_bank_pkg::PIN_2_7] = altDrive.sysMgmtIrqOutN;
            forceOut[gpio_bank_pkg::PIN_2_7] = 1'b1;
        end
        if (s.cfg[gpio_bank_pkg::PIN_3_0].func[0])
        begin
            forceIn[gpio_bank_pkg::PIN_3_0] = 1'b1;
            next_s.sense.fanSpeedSenseB = li[gpio_bank_pkg::PIN_3_0];
        end
        if (s.cfg[gpio_bank_pkg::PIN_3_1].func[0])
        begin
            forceIn[gpio_bank_pkg::PIN_3_1] = 1'b1;
            next_s.sense.fanSpeedSenseA = li[gpio_bank_pkg::PIN_3_1];
        end

        // ----------------------------------------
        // pad drivers
        // ----------------------------------------
        // input-only functions override the direction bit so a stray output
        // setting cannot fight an external tachometer or serial source
        for (int i = 0; i < gpio_bank_pkg::PIN_COUNT; i++)
        begin
            outEn = (!s.cfg[i].dirIn || forceOut[i]) && !forceIn[i];
            val = src[i] ^ s.cfg[i].invert;
            if (s.cfg[i].openDrain)
            begin
                next_s.padOut[i] = 1'b0;
                next_s.padOe[i] = outEn && !val;
            end
            else
            begin
                next_s.padOut[i] = val;
                next_s.padOe[i] = outEn;
            end
        end

        // ----------------------------------------
        // interrupt status: read clears, a new edge wins
        // ----------------------------------------
        if (regReq.rd && regReq.addr == gpio_bank_pkg::OFF_IRQ_STATUS)
        begin
            next_s.status = '0;
        end
        next_s.status = next_s.status | ev;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.cfg <= {gpio_bank_pkg::PIN_COUNT{gpio_bank_pkg::CFG_RESET}};
            s.status <= gpio_bank_pkg::IRQ_RESET;
            s.mask <= gpio_bank_pkg::IRQ_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign regRdata = s.rdata;
    assign gpioInData = s.gpioIn;
    assign padOut = s.padOut;
    assign padOe = s.padOe;
    assign altSense = s.sense;
    assign irq = |(s.status & s.mask);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence cfgWrite(int idx, logic [7:0] v);
        regReq.wr && regReq.addr == gpio_bank_pkg::PIN_CTL_OFFSET[idx] && regReq.wdata == v;
    endsequence

    sequence edgeOnPin21;
        s.cfg[gpio_bank_pkg::PIN_2_1].func == gpio_bank_pkg::FUNC_EDGE ##1
        $changed(s.sync2[gpio_bank_pkg::PIN_2_1]);
    endsequence

    AST_DIR_INPUT: assert property (s.cfg[gpio_bank_pkg::PIN_2_4].dirIn |=> !padOe[gpio_bank_pkg::PIN_2_4])
        else $error("input pin is driven");
    AST_POL_OUT: assert property (cfgWrite(gpio_bank_pkg::PIN_2_4, 8'h02) ##1 $stable(gpioOutData) |=>
        padOe[gpio_bank_pkg::PIN_2_4] && padOut[gpio_bank_pkg::PIN_2_4] == !$past(gpioOutData[4]))
        else $error("inverted output level wrong");
    AST_OPEN_DRAIN: assert property (s.cfg[gpio_bank_pkg::PIN_2_4] == 8'h80 |=>
        !padOut[4] && padOe[4] == !$past(gpioOutData[4]))
        else $error("open drain drive wrong");
    AST_RESERVED_MASK: assert property (cfgWrite(gpio_bank_pkg::PIN_1_7, 8'hFF) |=>
        s.cfg[gpio_bank_pkg::PIN_1_7] == 8'h87 ##1 s.cfg[gpio_bank_pkg::PIN_1_7] == 8'h87 || regReq.wr)
        else $error("reserved bits stored");
    AST_RSVD_SLOT: assert property (regReq.rd && regReq.addr == gpio_bank_pkg::OFF_RESERVED_SLOT |=>
        regRdata == 8'h00)
        else $error("reserved slot read nonzero");
    AST_NO_FUNC: assert property (cfgWrite(gpio_bank_pkg::PIN_2_4, 8'hFF) |=>
        s.cfg[gpio_bank_pkg::PIN_2_4] == 8'h83)
        else $error("pin 2.4 function bit stored");
    AST_RESET_LOAD: assert property ($past(nrst) == 1'b0 |-> s.cfg[gpio_bank_pkg::PIN_3_1] == 8'h01 &&
        s.cfg[gpio_bank_pkg::PIN_1_7] == 8'h01)
        else $error("reset value wrong");
    AST_EDGE_IRQ: assert property (edgeOnPin21 |=> s.status[0])
        else $error("edge not latched");
    AST_TX_DRIVE: assert property (s.cfg[gpio_bank_pkg::PIN_2_6] == 8'h05 |=>
        padOe[6] && padOut[6] == $past(altDrive.musicSerialTx))
        else $error("transmit not driven");
    AST_SMI_DRIVE: assert property (s.cfg[gpio_bank_pkg::PIN_2_7] == 8'h04 |=>
        padOe[7] && padOut[7] == $past(altDrive.sysMgmtIrqOutN))
        else $error("interrupt output not driven");
    AST_FAN_SENSE: assert property (s.cfg[gpio_bank_pkg::PIN_3_1] == 8'h04 |=>
        !padOe[9] && altSense.fanSpeedSenseA == $past(s.sync2[9]))
        else $error("fan sense wrong");

endmodule : gpio_pin_config_bank

// file: tb/pad_model.sv
// external pad model for the pin configuration bank
// assumes the bench drives extLevel/extDrive in place of the parts outside the chip
module pad_model (
    input wire logic clk_sys,
    input wire logic [gpio_bank_pkg::PIN_COUNT-1:0] padOut,
    input wire logic [gpio_bank_pkg::PIN_COUNT-1:0] padOe,
    input wire logic [gpio_bank_pkg::PIN_COUNT-1:0] extLevel,
    input wire logic [gpio_bank_pkg::PIN_COUNT-1:0] extDrive,
    output logic [gpio_bank_pkg::PIN_COUNT-1:0] padIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // wire resolution
    // ----------------------------------------
    logic [gpio_bank_pkg::PIN_COUNT-1:0] floatLevel = '0;

    // an undriven pad wanders every cycle, so a stale level never passes for a real one
    always_ff @(posedge clk_sys)
    begin
        floatLevel <= ~floatLevel;
    end

    // the chip wins while it drives; otherwise the outside part, else the floating level
    assign padIn = (padOe & padOut) | (~padOe & extDrive & extLevel) | (~padOe & ~extDrive & floatLevel);
endmodule : pad_model

// file: tb/tb_top.sv
// self-checking bench for the pin configuration bank
// assumes read data one cycle after the strobe and pads resolved by pad_model
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    gpio_bank_pkg::reg_req_t regReq = '0;
    logic [7:0] regRdata;
    logic [9:0] gpioOutData = '0;
    logic [9:0] gpioInData;
    logic [9:0] padIn;
    logic [9:0] padOut;
    logic [9:0] padOe;
    logic [9:0] extLevel = '0;
    logic [9:0] extDrive = '0;
    gpio_bank_pkg::alt_drive_t altDrive = '0;
    gpio_bank_pkg::alt_sense_t altSense;
    logic irq;
    int n_fail = 0;
    int checked = 0;
    logic [7:0] expQ[$];
    logic [7:0] expV;
    logic rdPend = 1'b0;
    logic [9:0] r;
    // first four entries drive the pin, the rest sense it
    int altPin[11] = '{2, 3, 6, 7, 0, 1, 2, 3, 5, 8, 9};
    logic [7:0] altCfg[11] = '{8'h0D, 8'h0D, 8'h05, 8'h04, 8'h05, 8'h05, 8'h05, 8'h05, 8'h04, 8'h04, 8'h04};
    int altBit[11] = '{3, 2, 1, 0, 6, 5, 4, 3, 2, 1, 0};

    gpio_pin_config_bank dut (.clk_sys(clk_sys), .nrst(nrst), .regReq(regReq), .regRdata(regRdata),
        .gpioOutData(gpioOutData), .gpioInData(gpioInData), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .altDrive(altDrive), .altSense(altSense), .irq(irq));

    pad_model pads (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe), .extLevel(extLevel),
        .extDrive(extDrive), .padIn(padIn));

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // bus tasks and read monitor
    // ----------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        regReq <= '0;
        @(posedge clk_sys);
    endtask : wr_reg

    // an all-unknown expectation marks a read whose value is not judged
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        regReq <= '0;
        @(posedge clk_sys);
    endtask : rd_reg

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : settle

    // read data launch on the rising edge; looking on the falling edge avoids racing that update
    always @(negedge clk_sys)
    begin
        if (rdPend)
        begin
            expV = expQ.pop_front();
            if (expV !== 8'hXX)
                `CHK(regRdata, expV)
        end
        rdPend <= regReq.rd;
    end

    task test_done;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    // the whole sequence needs under a thousand cycles
    initial
    begin
        #20000;
        n_fail++;
        test_done();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(91));
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        extDrive <= '1;
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++)
            rd_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], gpio_bank_pkg::CFG_RESET);
        rd_reg(gpio_bank_pkg::OFF_RESERVED_SLOT, 8'h00);
        rd_reg(8'h50, 8'h00);
        rd_reg(gpio_bank_pkg::OFF_IRQ_STATUS, 8'h00);
        rd_reg(gpio_bank_pkg::OFF_IRQ_MASK, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], 8'hFF);
            rd_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], gpio_bank_pkg::PIN_WMASK[i]);
        end
        wr_reg(gpio_bank_pkg::OFF_RESERVED_SLOT, 8'hFF);
        rd_reg(gpio_bank_pkg::OFF_RESERVED_SLOT, 8'h00);
        for (int i = 0; i < 10; i++)
        begin
            r = 10'($urandom);
            gpioOutData <= r;
            extLevel <= r;
            wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], 8'h00);
            settle(3);
            `CHK(padOe[i], 1'b1)
            `CHK(padOut[i], r[i])
            @(posedge clk_sys);
            wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], 8'h02);
            settle(3);
            `CHK(padOut[i], ~r[i])
            @(posedge clk_sys);
            wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], 8'h80);
            settle(3);
            `CHK(padOe[i], ~r[i])
            `CHK(padOut[i], 1'b0)
            @(posedge clk_sys);
            wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[i], 8'h03);
            settle(4);
            `CHK(padOe[i], 1'b0)
            `CHK(gpioInData[i], ~r[i])
            @(posedge clk_sys);
        end
        for (int k = 0; k < 11; k++)
        begin
            r = 10'($urandom);
            altDrive <= gpio_bank_pkg::alt_drive_t'(r[7:0]);
            extLevel <= r;
            wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[altPin[k]], altCfg[k]);
            settle(4);
            `CHK(padOe[altPin[k]], k < 4)
            if (k < 4)
                `CHK(padOut[altPin[k]], r[altBit[k]])
            else
                `CHK(altSense[altBit[k]], r[altPin[k]])
            @(posedge clk_sys);
        end
        // a level change on entering edge mode may flag once, so clear before judging
        extLevel <= '0;
        wr_reg(gpio_bank_pkg::OFF_IRQ_MASK, 8'h01);
        wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[2], 8'h08);
        wr_reg(gpio_bank_pkg::PIN_CTL_OFFSET[3], 8'h08);
        settle(4);
        @(posedge clk_sys);
        rd_reg(gpio_bank_pkg::OFF_IRQ_STATUS, 8'hXX);
        settle(1);
        `CHK(padOe[2], 1'b0)
        `CHK(irq, 1'b0)
        @(posedge clk_sys);
        extLevel <= 10'h00C;
        settle(4);
        `CHK(irq, 1'b1)
        @(posedge clk_sys);
        rd_reg(gpio_bank_pkg::OFF_IRQ_STATUS, 8'h03);
        settle(1);
        `CHK(irq, 1'b0)
        @(posedge clk_sys);
        rd_reg(gpio_bank_pkg::OFF_IRQ_STATUS, 8'h00);
        extLevel <= 10'h008;
        wr_reg(gpio_bank_pkg::OFF_IRQ_MASK, 8'h00);
        settle(4);
        `CHK(irq, 1'b0)
        @(posedge clk_sys);
        rd_reg(gpio_bank_pkg::OFF_IRQ_STATUS, 8'h01);
        rd_reg(gpio_bank_pkg::OFF_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk_sys);
        test_done();
    end
endmodule : tb_top
